// ==== fpb_pkg.sv ====
// Shared constants and types for the potential exception bounce unit
package fpb_pkg;

  localparam int unsigned FPB_EXP_W = 11;
  localparam int unsigned FPB_CALC_W = 13;
  localparam int unsigned FPB_SP_EXP_W = 8;
  localparam int unsigned FPB_NUM_OPND = 2;

  // Biased overflow and underflow bounce limits
  localparam logic [12:0] FPB_DP_OVF_MIN = 13'h07FD;
  localparam logic [12:0] FPB_SP_OVF_MIN = 13'h00FD;
  localparam logic [12:0] FPB_DP_USA_UNF_MAX = 13'h003F;
  localparam logic [12:0] FPB_SP_USA_UNF_MAX = 13'h001F;
  localparam logic [12:0] FPB_DP_LSA_UNF_MAX = 13'h0000;
  localparam logic [12:0] FPB_SP_LSA_UNF_MAX = 13'h0000;
  localparam logic [12:0] FPB_DP_MUL_UNF_MAX = 13'h0000;
  localparam logic [12:0] FPB_SP_MUL_UNF_MAX = 13'h0000;

  // Exponent biases for the product exponent
  localparam logic [12:0] FPB_DP_BIAS = 13'h03FF;
  localparam logic [12:0] FPB_SP_BIAS = 13'h007F;

  // Field positions in the status-control and exception words
  localparam int unsigned FPB_FTZ_BIT = 24;
  localparam int unsigned FPB_EXC_PEND_BIT = 31;
  localparam int unsigned FPB_UNF_BIT = 3;
  localparam logic [31:0] FPB_EXC_RESET = 32'h0000_0000;

  typedef enum logic [3:0] {
    FPB_OP_ADD,
    FPB_OP_SUB,
    FPB_OP_MUL,
    FPB_OP_NMUL,
    FPB_OP_CMP,
    FPB_OP_CMPZ,
    FPB_OP_CMPS,
    FPB_OP_CMPSZ,
    FPB_OP_OTHER
  } fpb_op_t;

  typedef struct packed {
    logic valid;
    fpb_op_t op;
    logic dp;
    logic sign_a;
    logic sign_b;
    logic [FPB_EXP_W-1:0] exp_a;
    logic [FPB_EXP_W-1:0] exp_b;
  } fpb_req_t;

  typedef struct packed {
    logic bounce;
    logic trap_req;
    logic write_en;
    logic write_suppress;
  } fpb_resp_t;

endpackage : fpb_pkg

// ==== fpb_thresh.sv ====
// Biased exponent threshold compare for one precision and class
`timescale 1ns/1ps
`default_nettype none
module fpb_thresh
  import fpb_pkg::*;
(
  // Initial exponent, biased, signed to catch values below zero
  input wire logic signed [FPB_CALC_W-1:0] exp_in,
  // Operation class
  input wire logic dp,
  input wire logic is_mul,
  input wire logic unlike,
  // Potential exception flags
  output logic pot_ovf,
  output logic pot_unf
);

  logic signed [FPB_CALC_W-1:0] ovf_min;
  logic signed [FPB_CALC_W-1:0] unf_max;

  always_comb begin
    ovf_min = dp ? FPB_DP_OVF_MIN : FPB_SP_OVF_MIN;
    if (is_mul) begin
      unf_max = dp ? FPB_DP_MUL_UNF_MAX : FPB_SP_MUL_UNF_MAX;
    end else if (unlike) begin
      // Cancellation can drop the exponent by a whole significand
      unf_max = dp ? FPB_DP_USA_UNF_MAX : FPB_SP_USA_UNF_MAX;
    end else begin
      unf_max = dp ? FPB_DP_LSA_UNF_MAX : FPB_SP_LSA_UNF_MAX;
    end
    pot_ovf = (exp_in >= ovf_min);
    pot_unf = (exp_in <= unf_max);
  end

endmodule : fpb_thresh
`default_nettype wire

// ==== fpb_bounce.sv ====
// Pessimistic bounce decision for add, subtract, compare and multiply
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Bounce on possible exception, never proving it really happened.
// - Add and subtract use the larger input exponent as initial.
// - Equal signs add or unequal signs subtract is like-signed, else unlike.
// - Double add bounces at 0x7FD and above, completes at 0x7FC.
// - Single add bounces at 0xFD and above for both classes.
// - Single unlike bounces at 0x1F or lower, like only at 0x00.
// - Double unlike bounces at 0x03F or lower, like only at 0x000.
// - Unlike underflow margin covers cancellation by a significand length.
// - Addition thresholds apply only with flush-to-zero clear.
// - All thresholds compare against biased exponents.
// - Compare instructions never bounce for arithmetic exceptions.
// - Multiply initial exponent is the sum of operand exponents less one bias.
// - Multiply bounces at 0x7FD double or 0xFD single and above.
// - Full compliance multiply bounces at 0x00 or lower, normal at 0x01.
// - Flush-to-zero is status-control bit 24; clear bounces underflows.
// - A bounced potential underflow sets exception bit 31 and underflow bit 3.
module fpb_bounce
  import fpb_pkg::*;
#(
  parameter int unsigned EXP_W = FPB_EXP_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Instruction with its initial exponents
  input wire fpb_req_t req,
  // Floating-point status and control word
  input wire logic [31:0] fp_status_control_reg,
  // Support code clears the exception word
  input wire logic exc_clear,
  // Decision towards the host core
  output fpb_resp_t resp_ff,
  output logic [31:0] fp_exception_reg_ff
);

  // The exponent path is sized for double operands plus a carry and sign
  if (EXP_W != FPB_EXP_W) begin : g_bad_exp_w
    $error("fpb_bounce: EXP_W must equal the double exponent width");
  end
  if (FPB_CALC_W < FPB_EXP_W + 2) begin : g_bad_calc_w
    $error("fpb_bounce: exponent sums need a carry and a sign bit");
  end
  if (FPB_SP_EXP_W >= FPB_EXP_W) begin : g_bad_sp_w
    $error("fpb_bounce: single exponent must be narrower than double");
  end
  if (FPB_FTZ_BIT >= $bits(fp_status_control_reg) ||
      FPB_EXC_PEND_BIT >= $bits(fp_exception_reg_ff)) begin : g_bad_bit
    $error("fpb_bounce: control and flag bits must fit their words");
  end

  function automatic logic is_compare(input fpb_op_t op);
    case (op)
      FPB_OP_CMP,
      FPB_OP_CMPZ,
      FPB_OP_CMPS,
      FPB_OP_CMPSZ: begin
        is_compare = 1'h1;
      end
      default: begin
        is_compare = 1'h0;
      end
    endcase
  endfunction : is_compare

  function automatic logic is_multiply(input fpb_op_t op);
    case (op)
      FPB_OP_MUL,
      FPB_OP_NMUL: begin
        is_multiply = 1'h1;
      end
      default: begin
        is_multiply = 1'h0;
      end
    endcase
  endfunction : is_multiply

  function automatic logic is_addsub(input fpb_op_t op);
    case (op)
      FPB_OP_ADD,
      FPB_OP_SUB: begin
        is_addsub = 1'h1;
      end
      default: begin
        is_addsub = 1'h0;
      end
    endcase
  endfunction : is_addsub

  function automatic logic is_unlike(
    input fpb_op_t op,
    input logic sign_a,
    input logic sign_b
  );
    is_unlike = (sign_a ^ sign_b) ^ (op == FPB_OP_SUB);
  endfunction : is_unlike

  function automatic logic [FPB_CALC_W-1:0] widen_exp(
    input logic [FPB_EXP_W-1:0] exp_raw,
    input logic dp
  );
    logic [FPB_CALC_W-1:0] wide;
    wide = '0;
    // Single exponents sit in the low bits; upper bits are ignored
    if (dp) begin
      wide[FPB_EXP_W-1:0] = exp_raw;
    end else begin
      wide[FPB_SP_EXP_W-1:0] = exp_raw[FPB_SP_EXP_W-1:0];
    end
    return wide;
  endfunction : widen_exp

  function automatic logic [FPB_CALC_W-1:0] product_bias(input logic dp);
    product_bias = dp ? FPB_DP_BIAS : FPB_SP_BIAS;
  endfunction : product_bias

  logic ftz;
  logic [FPB_EXP_W-1:0] raw_exp [FPB_NUM_OPND];
  logic [FPB_CALC_W-1:0] wide_exp [FPB_NUM_OPND];
  logic [FPB_CALC_W-1:0] larger_exp;
  logic [FPB_CALC_W-1:0] exp_sum;
  logic [FPB_CALC_W-1:0] prod_exp;
  logic signed [FPB_CALC_W-1:0] init_exp;
  logic op_add;
  logic op_mul;
  logic op_cmp;
  logic arith;
  logic unlike;
  logic pot_ovf;
  logic pot_unf;
  logic bounce;
  logic unf_event;
  fpb_resp_t nxt_resp;
  logic [31:0] nxt_exc;

  assign ftz = fp_status_control_reg[FPB_FTZ_BIT];
  assign raw_exp[0] = req.exp_a;
  assign raw_exp[1] = req.exp_b;

  genvar gi;
  for (gi = 0; gi < FPB_NUM_OPND; gi++) begin : g_opnd
    assign wide_exp[gi] = widen_exp(raw_exp[gi], req.dp);
  end

  always_comb begin
    op_add = is_addsub(req.op);
    op_mul = is_multiply(req.op);
    op_cmp = is_compare(req.op);
    arith = op_add || op_mul;
    unlike = is_unlike(req.op, req.sign_a, req.sign_b);
  end

  always_comb begin
    if (wide_exp[0] > wide_exp[1]) begin
      larger_exp = wide_exp[0];
    end else begin
      larger_exp = wide_exp[1];
    end
    // Both biased exponents carry the bias, so one bias comes off
    exp_sum = wide_exp[0] + wide_exp[1];
    prod_exp = exp_sum - product_bias(req.dp);
    // Kept signed so a product far below zero still reads as underflow
    if (op_mul) begin
      init_exp = $signed(prod_exp);
    end else begin
      init_exp = $signed(larger_exp);
    end
  end

  fpb_thresh u_thresh (
    .exp_in(init_exp),
    .dp(req.dp),
    .is_mul(op_mul),
    .unlike(unlike),
    .pot_ovf(pot_ovf),
    .pot_unf(pot_unf)
  );

  always_comb begin
    nxt_resp = '0;
    bounce = 1'h0;
    // Flush mode resolves underflow in hardware, so nothing bounces
    if (req.valid && arith && !op_cmp && !ftz) begin
      // Pessimistic: the margin is taken, the real status is not proven
      bounce = pot_ovf || pot_unf;
    end
    unf_event = bounce && pot_unf;
    nxt_resp.bounce = bounce;
    nxt_resp.trap_req = bounce;
    nxt_resp.write_suppress = bounce;
    nxt_resp.write_en = req.valid && !bounce;
  end

  always_comb begin
    nxt_exc = fp_exception_reg_ff;
    if (exc_clear) begin
      nxt_exc = FPB_EXC_RESET;
    end
    // A new event in the clearing cycle wins over the clear
    if (unf_event) begin
      nxt_exc[FPB_EXC_PEND_BIT] = 1'h1;
      nxt_exc[FPB_UNF_BIT] = 1'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      resp_ff <= '0;
    end else begin
      resp_ff <= nxt_resp;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fp_exception_reg_ff <= FPB_EXC_RESET;
    end else begin
      fp_exception_reg_ff <= nxt_exc;
    end
  end

endmodule : fpb_bounce
`default_nettype wire

// ==== fpb_checker.sv ====
// Port checks for the bounce unit
`timescale 1ns/1ps
`default_nettype none
module fpb_checker
  import fpb_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Request side
  input wire fpb_req_t req,
  input wire logic [31:0] fp_status_control_reg,
  input wire logic exc_clear,
  // Decision side
  input wire fpb_resp_t resp_ff,
  input wire logic [31:0] fp_exception_reg_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_live;
    req.valid && !fp_status_control_reg[FPB_FTZ_BIT];
  endsequence
  sequence s_flush;
    req.valid && fp_status_control_reg[FPB_FTZ_BIT];
  endsequence
  sequence s_pend_rise;
    $rose(fp_exception_reg_ff[FPB_EXC_PEND_BIT]);
  endsequence
  a_idle_quiet: assert property (!req.valid |=> resp_ff == '0)
    else $error("response without request");
  a_ftz_quiet: assert property (s_flush |=> !resp_ff.bounce)
    else $error("bounce in flush mode");
  a_cmp_never: assert property (req.valid &&
    req.op inside {[FPB_OP_CMP:FPB_OP_CMPSZ]} |=> !resp_ff.bounce)
    else $error("compare bounced");
  a_add_ovf: assert property (s_live ##0 req.op == FPB_OP_ADD &&
    req.dp && req.exp_a >= 11'h7FD |=> resp_ff.bounce)
    else $error("double add overflow kept");
  a_mul_ovf: assert property (s_live ##0 req.op == FPB_OP_MUL &&
    !req.dp && req.exp_a[7:0] == 8'h7F && req.exp_b[7:0] >= 8'hFD |=>
    resp_ff.bounce)
    else $error("single product overflow kept");
  a_usa_unf: assert property (s_live ##0 req.op == FPB_OP_ADD &&
    req.dp && req.sign_a != req.sign_b && req.exp_a <= 11'h03F &&
    req.exp_b <= 11'h03F |=> resp_ff.bounce &&
    fp_exception_reg_ff[FPB_UNF_BIT])
    else $error("double unlike underflow kept");
  a_trap_pair: assert property (resp_ff.bounce |->
    resp_ff.trap_req && resp_ff.write_suppress && !resp_ff.write_en)
    else $error("bounce without trap");
  a_unf_flags: assert property (s_pend_rise |->
    fp_exception_reg_ff[FPB_UNF_BIT] && resp_ff.bounce)
    else $error("flags without underflow bounce");
  a_exc_clear: assert property (exc_clear && !req.valid |=>
    fp_exception_reg_ff == FPB_EXC_RESET)
    else $error("exception word kept");
endmodule : fpb_checker
bind fpb_bounce fpb_checker u_chk (.clk_sys, .rstn, .req,
  .fp_status_control_reg, .exc_clear, .resp_ff, .fp_exception_reg_ff);
`default_nettype wire

// ==== fpb_host_model.sv ====
// Host core and support code stand-in
`timescale 1ns/1ps
`default_nettype none
module fpb_host_model
  import fpb_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Decision and reply pace
  input wire fpb_resp_t resp_ff,
  input wire logic slow,
  // Clear of the exception word
  output logic exc_clear
);
  logic pend;
  // Clears only after the trap, slow replies a cycle late
  always @(negedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pend <= 1'h0;
      exc_clear <= 1'h0;
    end else begin
      pend <= resp_ff.trap_req;
      exc_clear <= slow ? pend : resp_ff.trap_req;
    end
  end
endmodule : fpb_host_model
`default_nettype wire

// ==== tb_top.sv ====
// Random boundary bench for the bounce unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fpb_pkg::*;
  logic clk_sys = 1'h0;
  logic rstn = 1'h0;
  logic exc_clear;
  logic slow = 1'h0;
  logic em = 1'h0;
  logic [35:0] got_v;
  logic [35:0] exp_v;
  logic [31:0] fp_status_control_reg = 32'h0000_0000;
  logic [31:0] fp_exception_reg_ff;
  logic [31:0] s = 32'h0000_5C50;
  fpb_req_t req = '0;
  fpb_resp_t resp_ff;
  logic [4:0] q[$];
  logic [4:0] n;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [10:0] tv [8] = '{11'h7FD, 11'h7FC, 11'h03F, 11'h001, 11'h0FD,
    11'h07F, 11'h000, 11'h3FF};
  always #25 clk_sys = ~clk_sys;
  fpb_bounce dut (.clk_sys, .rstn, .req, .fp_status_control_reg,
    .exc_clear, .resp_ff, .fp_exception_reg_ff);
  fpb_host_model u_host (.clk_sys, .rstn, .resp_ff, .slow, .exc_clear);
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  function automatic logic [4:0] model(fpb_req_t r, logic f);
    logic [10:0] a, b;
    int e;
    logic un, ov, mul, bnc;
    a = r.dp ? r.exp_a : {3'h0, r.exp_a[7:0]};
    b = r.dp ? r.exp_b : {3'h0, r.exp_b[7:0]};
    mul = r.op inside {FPB_OP_MUL, FPB_OP_NMUL};
    e = mul ? int'(a) + int'(b) - int'(r.dp ? FPB_DP_BIAS : FPB_SP_BIAS)
      : int'(a > b ? a : b);
    ov = e >= int'(r.dp ? FPB_DP_OVF_MIN : FPB_SP_OVF_MIN);
    un = e <= ((!mul && r.sign_a ^ r.sign_b ^ (r.op == FPB_OP_SUB)) ?
      (r.dp ? 63 : 31) : 0);
    bnc = r.valid && !f && r.op <= FPB_OP_NMUL && (ov || un);
    return {bnc, bnc, r.valid && !bnc, bnc, bnc && un};
  endfunction : model
  task automatic chk(string nm, logic [35:0] got, logic [35:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 12000) begin
      failures++;
      end_sim();
    end
    #1;
    if (q.size() > 0) begin
      n = q.pop_front();
      // Sticky flags drop on a clear unless a new underflow arrives
      em = n[0] | (em & !exc_clear);
      got_v = {resp_ff, fp_exception_reg_ff};
      exp_v = {n[4:1], em, 27'h0, em, 3'h0};
      chk("resp", got_v, exp_v);
    end
  end
  initial begin
    repeat (16) @(negedge clk_sys);
    rstn = 1'h1;
    repeat (10000) begin
      @(negedge clk_sys);
      s = xs(s);
      req = {s[0] | s[1], fpb_op_t'(s[5:2] % 4'h9), s[8:6],
        s[12] ? tv[s[11:9]] : s[23:13], s[24] ? tv[s[27:25]] : s[31:21]};
      fp_status_control_reg[FPB_FTZ_BIT] = s[31:28] == 4'h0;
      // Nonblocking: the host model samples this on the next falling edge
      slow <= s[28];
      q.push_back(model(req, fp_status_control_reg[FPB_FTZ_BIT]));
    end
    repeat (2) @(negedge clk_sys);
    $display("test random done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
